// *** vol_preset_defs.svh ***
// Constants for the volume and preset button controller.
// Assumes a 200 MHz core clock and a 32-bit classic Wishbone slave port.
`ifndef VOL_PRESET_DEFS_SVH
`define VOL_PRESET_DEFS_SVH
`define CLK_MHZ       200
`define CLK_NS        5
`define OFF_CTRL      12'h000
`define OFF_DGAIN     12'h004
`define OFF_SLEW      12'h008
`define OFF_ATTEN     12'h00C
`define OFF_STATUS    12'h010
`define OFF_PRESET    12'h014
`define OFF_SAVE      12'h018
`define BAND_TAG      4'h1
`define VTAB_TAG      3'h1
`define VTAB_N        7'h64
`define VTAB_LAST     7'h63
`define GAIN_MUTE     7'h7F
`define GAIN_FLOOR    7'h7E
`define BANDS         3'h5
`define BAND_POS      5'h0F
`define BAND_NEG      5'h11
`define RST_CTRL      7'h70
`define RST_SLEW      16'h00C8
`define RST_ATTEN     7'h03
`define RST_VIDX      7'h32
`define RST_PULL      4'hF
`define STS_IDX       8
`define STS_PRE       16
`define STS_MUTE      20
`define STS_GUARD     21
`define STS_SLEW      22
`define SAVE_BIT      0
`define GUARD_NS      30
`define DEB_US        5000
`define HOLD_MS       2000
`define REP_MS        200
`define TONE_MS       100
`define TONE_HZ       1000
`define TONE_WRAP_HZ  2000
`endif

// *** vol_preset_pkg.sv ***
// Types shared by the volume and preset button controller.
// Assumes vol_preset_defs.svh supplies the numeric constants.
package vol_preset_pkg;
    typedef enum logic {TONE_IDLE, TONE_PLAY} tone_state_t;
    typedef struct packed {
        logic [2:0] preset_last;
        logic       mute;
        logic       direct;
        logic       tone_en;
        logic       autorep;
    } ctrl_t;
endpackage

// *** volume_and_preset_button_control.sv ***
// Master gain, mute, thermal attenuation and equalizer preset control.
// Assumes button and guard inputs synchronous to clk_i; Wishbone classic master.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "vol_preset_defs.svh"

// Operation
// [R1] One master gain code drives all three audio channels.
// [R2] Gain code spans +24 to -102 dB in 1 dB steps plus mute.
// [R3] Hundred-entry volume table; index steps on up and down presses.
// [R4] Bus write of direct gain bypasses the table index.
// [R5] Every gain change slews one dB per programmable interval.
// [R6] Pull-ups on volume and mute buttons enabled from reset; active low.
// [R7] All buttons debounced internally; bounce yields no extra events.
// [R8] Held up/down button autorepeats after two seconds when enabled.
// [R9] Each mute press toggles mute for all channels.
// [R10] Guard input pull-down enabled from reset.
// [R11] Guard high 30 ns applies programmable attenuation, default 3 dB.
// [R12] Attenuation holds until guard falls; entry and exit slewed.
// [R13] Five bands of +-15 dB gain, up to eight presets stored.
// [R14] Preset chosen by button or by bus writes of preset and bands.
// [R15] Preset press advances pointer, wrapping after the last preset.
// [R16] Preset button has same pull-up and debounce as volume buttons.
// [R17] Tone on preset advance when enabled; distinct pitch on wrap.
// [R18] Request EEPROM save of volume index and preset selection.
// [R19] Table index saturates at 0 and 99, never wraps.
// [R20] Unmute slews back to pre-mute level including active attenuation.
module volume_and_preset_button_control
    import vol_preset_pkg::*;
#(
    parameter logic [31:0] DEB_CYC   = 32'(`DEB_US * `CLK_MHZ),
    parameter logic [31:0] HOLD_CYC  = 32'(`HOLD_MS * 1000 * `CLK_MHZ),
    parameter logic [31:0] REP_CYC   = 32'(`REP_MS * 1000 * `CLK_MHZ),
    parameter logic [31:0] TONE_CYC  = 32'(`TONE_MS * 1000 * `CLK_MHZ),
    parameter logic [31:0] HALF_NORM = 32'(`CLK_MHZ * 1000000 / (2 * `TONE_HZ)),
    parameter logic [31:0] HALF_WRAP = 32'(`CLK_MHZ * 1000000 / (2 * `TONE_WRAP_HZ))
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        gain_step_up_btn_n_i,
    input  wire logic        gain_step_down_btn_n_i,
    input  wire logic        mute_btn_n_i,
    input  wire logic        eq_preset_button_n_i,
    input  wire logic        thermal_guard_in_i,
    output logic      [3:0]  btn_pullup_en_o,
    output logic             guard_pulldown_en_o,
    output logic      [6:0]  master_gain_o,
    output logic             gain_muted_o,
    output logic      [6:0]  vol_index_o,
    output logic      [2:0]  eq_preset_o,
    output logic      [24:0] eq_band_gains_o,
    output logic             tone_o,
    output logic             save_req_o
);
    localparam int GUARD_CYC = (`GUARD_NS + `CLK_NS - 1) / `CLK_NS;

    function automatic logic [5:0] band_idx(input logic [2:0] p, input logic [2:0] b);
        band_idx = 6'(p) * 6'(`BANDS) + 6'(b);
    endfunction

    function automatic logic [4:0] band_sat(input logic [7:0] v);
        if (!v[7] && v > 8'(`BAND_POS))
            band_sat = `BAND_POS;
        else if (v[7] && v < {3'h7, `BAND_NEG})
            band_sat = `BAND_NEG;
        else
            band_sat = v[4:0];
    endfunction

    ctrl_t       ctrl;
    logic [6:0]  dgain;
    logic [15:0] slew_div;
    logic [15:0] slew_cnt;
    logic [6:0]  atten;
    logic [6:0]  vtab [100];
    logic [4:0]  band [40];
    logic [3:0]  stable;
    logic [3:0]  stable_q;
    logic [31:0] deb_cnt [4];
    logic [31:0] hold_cnt [2];
    logic [1:0]  rep;
    logic [2:0]  guard_cnt;
    logic        guard_active;
    tone_state_t tone_state;
    logic [31:0] tone_len;
    logic [31:0] tone_ph;
    logic [31:0] tone_half;

    logic [3:0]  raw;
    logic [3:0]  press;
    logic        up_evt;
    logic        dn_evt;
    logic        bus_req;
    logic        bus_wr;
    logic        in_vtab;
    logic        in_band;
    logic [6:0]  vt_a;
    logic [2:0]  bp;
    logic [2:0]  bb;
    logic [6:0]  base;
    logic [7:0]  sum;
    logic [6:0]  target;
    logic        pre_wrap;
    logic        save_wr;
    logic [31:0] rdata;

    // ----------------------------------------------------------------
    // Button conditioning
    // ----------------------------------------------------------------
    assign raw = ~{eq_preset_button_n_i, mute_btn_n_i,
                   gain_step_down_btn_n_i, gain_step_up_btn_n_i}; // [R6] [R16]
    assign press = stable & ~stable_q;
    assign up_evt = press[0] | rep[0];
    assign dn_evt = press[1] | rep[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            btn_pullup_en_o     <= `RST_PULL; // [R6] [R16]
            guard_pulldown_en_o <= 1'b1; // [R10]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stable   <= '0;
            stable_q <= '0;
            for (int i = 0; i < 4; i++) begin
                deb_cnt[i] <= '0;
            end
        end else if (ce_i) begin
            stable_q <= stable;
            for (int i = 0; i < 4; i++) begin
                if (raw[i] == stable[i]) begin
                    deb_cnt[i] <= '0;
                end else if (deb_cnt[i] >= DEB_CYC - 32'h1) begin
                    stable[i]  <= raw[i]; // [R7]
                    deb_cnt[i] <= '0;
                end else begin
                    deb_cnt[i] <= deb_cnt[i] + 32'h1;
                end
            end
        end
    end

    // Autorepeat on the two volume buttons
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rep         <= '0;
            hold_cnt[0] <= '0;
            hold_cnt[1] <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < 2; i++) begin
                rep[i] <= 1'b0;
                if (!stable[i] || !ctrl.autorep) begin
                    hold_cnt[i] <= '0;
                end else if (hold_cnt[i] >= HOLD_CYC - 32'h1) begin
                    rep[i]      <= 1'b1; // [R8]
                    hold_cnt[i] <= HOLD_CYC - REP_CYC;
                end else begin
                    hold_cnt[i] <= hold_cnt[i] + 32'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Thermal guard
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            guard_cnt    <= '0;
            guard_active <= 1'b0;
        end else if (ce_i) begin
            if (!thermal_guard_in_i) begin
                guard_cnt    <= '0;
                guard_active <= 1'b0; // [R12]
            end else if (32'(guard_cnt) < 32'(GUARD_CYC - 1)) begin
                guard_cnt <= guard_cnt + 3'h1;
            end else begin
                guard_active <= 1'b1; // [R11]
            end
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    assign vt_a    = wb_adr_i[8:2];
    assign bp      = wb_adr_i[7:5];
    assign bb      = wb_adr_i[4:2];
    assign in_vtab = (wb_adr_i[11:9] == `VTAB_TAG) && (vt_a < `VTAB_N);
    assign in_band = (wb_adr_i[11:8] == `BAND_TAG) && (bb < `BANDS);
    assign save_wr = bus_wr && (wb_adr_i == `OFF_SAVE) && wb_dat_i[`SAVE_BIT];

    always_comb begin
        rdata = '0;
        if (in_vtab) begin
            rdata[6:0] = vtab[vt_a];
        end else if (in_band) begin
            rdata = 32'(signed'(band[band_idx(bp, bb)]));
        end else begin
            case (wb_adr_i)
                `OFF_CTRL:   rdata[6:0]  = ctrl;
                `OFF_DGAIN:  rdata[6:0]  = dgain;
                `OFF_SLEW:   rdata[15:0] = slew_div;
                `OFF_ATTEN:  rdata[6:0]  = atten;
                `OFF_PRESET: rdata[2:0]  = eq_preset_o;
                `OFF_STATUS: begin
                    rdata[6:0]              = master_gain_o;
                    rdata[`STS_IDX +: 7]    = vol_index_o;
                    rdata[`STS_PRE +: 3]    = eq_preset_o;
                    rdata[`STS_MUTE]        = ctrl.mute;
                    rdata[`STS_GUARD]       = guard_active;
                    rdata[`STS_SLEW]        = master_gain_o != target;
                end
                default:     rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rdata : '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= ctrl_t'(`RST_CTRL);
            dgain    <= '0;
            slew_div <= `RST_SLEW;
            atten    <= `RST_ATTEN; // [R11]
        end else if (ce_i) begin
            if (bus_wr && wb_adr_i == `OFF_CTRL) begin
                ctrl <= ctrl_t'(wb_dat_i[6:0]);
            end
            if (bus_wr && wb_adr_i == `OFF_DGAIN) begin
                dgain       <= wb_dat_i[6:0];
                ctrl.direct <= 1'b1; // [R4]
            end
            if (up_evt || dn_evt) begin
                ctrl.direct <= 1'b0;
            end
            if (press[2]) begin
                ctrl.mute <= ~ctrl.mute; // [R9]
            end
            if (bus_wr && wb_adr_i == `OFF_SLEW) begin
                slew_div[7:0] <= wb_dat_i[7:0];
            end
            if (bus_req && wb_we_i && wb_sel_i[1] && wb_adr_i == `OFF_SLEW) begin
                slew_div[15:8] <= wb_dat_i[15:8];
            end
            if (bus_wr && wb_adr_i == `OFF_ATTEN) begin
                atten <= wb_dat_i[6:0];
            end
        end
    end

    // Volume table and band gain stores
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 100; i++) begin
                vtab[i] <= `GAIN_FLOOR - 7'(i);
            end
            for (int i = 0; i < 40; i++) begin
                band[i] <= '0;
            end
        end else if (ce_i) begin
            if (bus_wr && in_vtab) begin
                vtab[vt_a] <= wb_dat_i[6:0]; // [R3]
            end
            if (bus_wr && in_band) begin
                band[band_idx(bp, bb)] <= band_sat(wb_dat_i[7:0]); // [R13] [R14]
            end
        end
    end

    // ----------------------------------------------------------------
    // Volume index, preset pointer and save request
    // ----------------------------------------------------------------
    assign pre_wrap = eq_preset_o >= ctrl.preset_last;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vol_index_o <= `RST_VIDX;
            eq_preset_o <= '0;
            save_req_o  <= 1'b0;
        end else if (ce_i) begin
            save_req_o <= save_wr; // [R18]
            if (up_evt && !dn_evt && vol_index_o < `VTAB_LAST) begin
                vol_index_o <= vol_index_o + 7'h1; // [R3] [R19]
                save_req_o  <= 1'b1; // [R18]
            end else if (dn_evt && !up_evt && vol_index_o != '0) begin
                vol_index_o <= vol_index_o - 7'h1; // [R3] [R19]
                save_req_o  <= 1'b1;
            end
            if (press[3]) begin
                eq_preset_o <= pre_wrap ? 3'h0 : eq_preset_o + 3'h1; // [R15]
                save_req_o  <= 1'b1; // [R18]
            end else if (bus_wr && wb_adr_i == `OFF_PRESET) begin
                eq_preset_o <= (wb_dat_i[2:0] > ctrl.preset_last) ?
                               ctrl.preset_last : wb_dat_i[2:0]; // [R14]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eq_band_gains_o <= '0;
        end else if (ce_i) begin
            for (int b = 0; b < 5; b++) begin
                eq_band_gains_o[b*5 +: 5] <= band[band_idx(eq_preset_o, 3'(b))]; // [R13]
            end
        end
    end

    // ----------------------------------------------------------------
    // Gain target and slew
    // ----------------------------------------------------------------
    always_comb begin
        base = ctrl.direct ? dgain : vtab[vol_index_o]; // [R4]
        sum  = {1'b0, base} + (guard_active ? {1'b0, atten} : 8'h00); // [R11]
        if (ctrl.mute)
            target = `GAIN_MUTE; // [R2]
        else if (sum > {1'b0, `GAIN_FLOOR})
            target = `GAIN_FLOOR; // [R20]
        else
            target = sum[6:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_gain_o <= `GAIN_MUTE;
            gain_muted_o  <= 1'b1;
            slew_cnt      <= '0;
        end else if (ce_i) begin
            gain_muted_o <= master_gain_o == `GAIN_MUTE;
            if (master_gain_o == target) begin
                slew_cnt <= '0;
            end else if (slew_cnt < slew_div) begin
                slew_cnt <= slew_cnt + 16'h1;
            end else begin
                slew_cnt <= '0;
                // One common gain for all channels, one dB per step
                if (master_gain_o < target)
                    master_gain_o <= master_gain_o + 7'h1; // [R1] [R5] [R12]
                else
                    master_gain_o <= master_gain_o - 7'h1; // [R1] [R5] [R20]
            end
        end
    end

    // ----------------------------------------------------------------
    // Preset tone
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tone_state <= TONE_IDLE;
            tone_o     <= 1'b0;
            tone_len   <= '0;
            tone_ph    <= '0;
            tone_half  <= HALF_NORM;
        end else if (ce_i) begin
            if (press[3] && ctrl.tone_en) begin
                tone_state <= TONE_PLAY;
                tone_len   <= '0;
                tone_ph    <= '0;
                tone_o     <= 1'b1;
                tone_half  <= pre_wrap ? HALF_WRAP : HALF_NORM; // [R17]
            end else begin
                case (tone_state)
                    TONE_IDLE: begin
                        tone_o <= 1'b0;
                    end
                    TONE_PLAY: begin
                        tone_len <= tone_len + 32'h1;
                        if (tone_len >= TONE_CYC - 32'h1) begin
                            tone_state <= TONE_IDLE;
                            tone_o     <= 1'b0;
                        end else if (tone_ph >= tone_half - 32'h1) begin
                            tone_ph <= '0;
                            tone_o  <= ~tone_o;
                        end else begin
                            tone_ph <= tone_ph + 32'h1;
                        end
                    end
                    default: tone_state <= TONE_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_guard_held;
        (thermal_guard_in_i && ce_i) [*6];
    endsequence

    a_guard_entry: assert property (s_guard_held |=> guard_active) // [R11]
        else $error("guard not active after 30 ns high");
    a_guard_exit: assert property (ce_i && !thermal_guard_in_i |=> !guard_active) // [R12]
        else $error("guard stayed active after release");
    a_index_sat: assert property (ce_i && up_evt && !dn_evt
        && vol_index_o == `VTAB_LAST |=> vol_index_o == `VTAB_LAST) // [R19]
        else $error("index passed the top entry");
    a_index_step: assert property (ce_i && up_evt && !dn_evt && vol_index_o < `VTAB_LAST
        |=> vol_index_o == $past(vol_index_o) + 7'h1 && save_req_o) // [R3]
        else $error("up press did not step index");
    a_preset_wrap: assert property (ce_i && press[3] && pre_wrap |=> eq_preset_o == 3'h0) // [R15]
        else $error("preset did not wrap");
    a_slew_one_db: assert property (ce_i |=> master_gain_o == $past(master_gain_o)
        || master_gain_o == $past(master_gain_o) + 7'h1
        || master_gain_o == $past(master_gain_o) - 7'h1) // [R5]
        else $error("gain jumped more than one step");
    a_mute_target: assert property (ce_i && ctrl.mute && master_gain_o == `GAIN_MUTE
        |=> master_gain_o == `GAIN_MUTE) // [R9]
        else $error("muted gain left mute");
    a_bus_ack: assert property (bus_req && ce_i |=> wb_ack_o ##1 !wb_ack_o || !ce_i) // [R4]
        else $error("bus request not answered in one cycle");
    a_tone_pitch: assert property (ce_i && press[3] && ctrl.tone_en && pre_wrap
        |=> tone_state == TONE_PLAY && tone_half == HALF_WRAP) // [R17]
        else $error("wrap tone pitch wrong");
    a_pulls_on: assert property (btn_pullup_en_o == `RST_PULL && guard_pulldown_en_o) // [R6]
        else $error("pull enables dropped");
endmodule

// *** panel_model.sv ***
// Pushbutton and guard-line model for the volume and preset controller.
// Assumes the bench calls its tasks; lines float to a pattern when pulls are off.
`timescale 1ns/1ps
module panel_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] pullup_en_i,
    input  wire logic       pulldown_en_i,
    output logic      [3:0] btn_n_o,
    output logic            guard_o
);
    logic [3:0] closed = 4'h0;
    logic       hot    = 1'b0;
    logic       tog    = 1'b0;
    always @(posedge clk_i) tog <= ~tog;
    assign btn_n_o = ~closed & (pullup_en_i | {4{tog}});
    assign guard_o = hot | (~pulldown_en_i & tog);
    // Close with bounce, hold, then open
    task automatic press(input int b, input int hold);
        repeat (3) begin
            @(posedge clk_i);
            closed[b] <= ~closed[b];
        end
        repeat (hold) @(posedge clk_i);
        closed[b] <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic guard(input logic on);
        @(posedge clk_i);
        hot <= on;
    endtask
endmodule

// *** volume_and_preset_button_control_test.sv ***
// Self-checking bench for the volume and preset controller.
// Assumes shortened debounce, repeat and tone counts set below.
`timescale 1ns/1ps
`include "vol_preset_defs.svh"
module volume_and_preset_button_control_test;
    localparam int HN = 4;
    localparam int HW = 2;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, rdat, wb_dat_o;
    logic        wb_ack_o, pd_en, muted, tone_o, save_req_o, guard;
    logic [3:0]  pu_en, btn_n, sel = 4'h0, lanes = 4'hF;
    logic [6:0]  master_gain_o, vol_index_o;
    logic [2:0]  eq_preset_o;
    logic [24:0] bands;
    int          num_errors = 0, tests_run = 0, saves = 0, cycles = 0, s0, h, g, v;
    always #2.5 clk_i = ~clk_i;
    volume_and_preset_button_control #(.DEB_CYC(32'd4), .HOLD_CYC(32'd40),
        .REP_CYC(32'd10), .TONE_CYC(32'd50), .HALF_NORM(32'd4), .HALF_WRAP(32'd2)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .gain_step_up_btn_n_i(btn_n[0]),
        .gain_step_down_btn_n_i(btn_n[1]), .mute_btn_n_i(btn_n[2]),
        .eq_preset_button_n_i(btn_n[3]), .thermal_guard_in_i(guard),
        .btn_pullup_en_o(pu_en), .guard_pulldown_en_o(pd_en),
        .master_gain_o(master_gain_o), .gain_muted_o(muted), .vol_index_o(vol_index_o),
        .eq_preset_o(eq_preset_o), .eq_band_gains_o(bands), .tone_o(tone_o),
        .save_req_o(save_req_o));
    panel_model i_panel (.clk_i(clk_i), .pullup_en_i(pu_en), .pulldown_en_i(pd_en),
        .btn_n_o(btn_n), .guard_o(guard));
    always @(posedge clk_i) if (save_req_o === 1'b1) saves <= saves + 1;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            close_out();
        end
    end
    function automatic logic [6:0] vtab(input int i);
        return 7'(126 - i);
    endfunction
    function automatic logic [6:0] guarded(input logic [6:0] b, input int a);
        return (int'(b) + a > 126) ? 7'd126 : 7'(int'(b) + a);
    endfunction
    task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic [6:0] got, input logic [6:0] exp);
        check_bus({25'h0, got}, {25'h0, exp});
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= lanes;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_gain(input logic [6:0] exp);
        int n;
        n = 0;
        while (master_gain_o !== exp && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        check_pin(master_gain_o, exp);
    endtask
    task automatic tone_half(output int hc);
        int n;
        n = 0;
        hc = 0;
        while (tone_o !== 1'b0 && n < 99) begin @(posedge clk_i); n++; end
        while (tone_o !== 1'b1 && n < 99) begin @(posedge clk_i); n++; end
        while (tone_o === 1'b1 && n < 99) begin @(posedge clk_i); n++; hc++; end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(12));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check_bus({27'h0, pd_en, pu_en}, 32'h1F);
        check_pin(vol_index_o, 7'h32);
        wb(0, `OFF_CTRL, 0);
        check_bus(rdat, 32'h70);
        lanes = 4'h2;
        wb(1, `OFF_ATTEN, 7);
        lanes = 4'hF;
        wb(0, `OFF_ATTEN, 0);
        check_bus(rdat, 32'h03);
        wb(0, 12'h7FC, 0);
        check_bus(rdat, 32'h0);
        $display("test reset done");
        wb(1, `OFF_SLEW, 0);
        wait_gain(vtab(50));
        wb(1, `OFF_SLEW, 9);
        wb(1, `OFF_DGAIN, 66);
        repeat (50) @(posedge clk_i);
        check_bus(32'(master_gain_o > 7'd66 && master_gain_o < 7'd76), 1);
        ce <= 1'b0;
        @(posedge clk_i);
        v = master_gain_o;
        repeat (20) @(posedge clk_i);
        check_pin(master_gain_o, 7'(v));
        ce <= 1'b1;
        wait_gain(7'd66);
        wb(1, `OFF_SLEW, 0);
        $display("test slew done");
        s0 = saves;
        i_panel.press(0, 10);
        check_pin(vol_index_o, 7'd51);
        check_bus(saves, s0 + 1);
        wait_gain(vtab(51));
        wb(1, `OFF_CTRL, 32'h71);
        i_panel.press(0, 700);
        check_pin(vol_index_o, 7'd99);
        i_panel.press(1, 10);
        check_pin(vol_index_o, 7'd98);
        $display("test buttons done");
        i_panel.press(2, 10);
        wait_gain(7'h7F);
        @(posedge clk_i);
        check_pin({6'h0, muted}, 7'd1);
        i_panel.guard(1);
        i_panel.press(2, 10);
        wait_gain(guarded(vtab(98), 3));
        i_panel.guard(0);
        wait_gain(vtab(98));
        i_panel.guard(1);
        repeat (3) @(posedge clk_i);
        i_panel.guard(0);
        repeat (20) @(posedge clk_i);
        check_pin(master_gain_o, vtab(98));
        wb(1, `OFF_ATTEN, 10);
        i_panel.guard(1);
        wait_gain(guarded(vtab(98), 10));
        i_panel.guard(0);
        wait_gain(vtab(98));
        $display("test mute and guard done");
        wb(1, `OFF_CTRL, 32'h23);
        for (int i = 1; i <= 3; i++) begin
            i_panel.press(3, 10);
            check_pin({4'h0, eq_preset_o}, 7'(i % 3));
            tone_half(h);
            check_bus(h, (i == 3) ? HW : HN);
        end
        wb(1, `OFF_PRESET, 1);
        check_pin({4'h0, eq_preset_o}, 7'd1);
        $display("test presets done");
        for (int k = 0; k < 6; k++) begin
            g = (k < 2) ? k * 126 : $urandom_range(0, 126);
            wb(1, `OFF_DGAIN, g);
            wait_gain(7'(g));
            v = $urandom_range(0, 40) - 20;
            h = $urandom_range(0, 4);
            wb(1, 12'(32'h120 + h * 4), 32'(v));
            wb(0, 12'(32'h120 + h * 4), 0);
            v = (v > 15) ? 15 : ((v < -15) ? -15 : v);
            check_bus({24'h0, rdat[7:0]}, {24'h0, 8'(v)});
            repeat (2) @(posedge clk_i);
            check_pin({2'h0, bands[5*h+:5]}, {2'h0, 5'(v)});
        end
        s0 = saves;
        wb(1, `OFF_SAVE, 1);
        repeat (2) @(posedge clk_i);
        check_bus(saves, s0 + 1);
        $display("test random and save done");
        close_out();
    end
endmodule
